// ==== hw/dxt_exec_xfer.sv ====
// Execution-phase data transfer of the disk controller: FIFO, DMA and interrupt requests.
// Assumes ISA strobes arrive asynchronously and the disk side runs on i_ref_clk.
// What this block does
// - FIFO off: request per byte, drop on acknowledge.
// - Acknowledge with AEN selects FIFO, address ignored.
// - Terminal count ends transfer, only acknowledge low.
// - Legacy mode: single byte, request drops between.
// - Alternate mode: level 0Fh, reassert acknowledge high.
// - Read: request at occupancy 16 minus level.
// - Read: request after sector end below level.
// - Read burst: hold request until FIFO empty.
// - Read non-burst: drop per byte, 350 ns gap.
// - Write: request while occupancy not above level.
// - Write burst: hold request until FIFO full.
// - Write non-burst: drop per byte, 350 ns gap.
// - Write: last sector byte drops request.
// - Acknowledge pulse drops request, counts a byte.
// - Held acknowledge: strobe end counts a byte.
// - Service timeout ends execution; host drains sector.
// - Underrun pads sector with last byte, then ends.
// - End interrupt; first result read clears it.
// - Non-DMA: interrupt replaces request, status bits.
// - After last byte: status 7,6 set, 5 clear.
// - Four-bit level; reset disables FIFO, level zero.
// - Mode picks burst; non-burst gap 350 ns.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module dxt_exec_xfer #(
  parameter int DEPTH = dxt_pkg::FIFO_DEPTH, // FIFO depth in bytes
  parameter int GAP = dxt_pkg::GAP_CYC // Non-burst gap in cycles
)(
  input wire logic i_ref_clk, // Controller clock
  input wire logic i_reset, // Synchronous reset, high
  input wire logic i_ce, // Clock enable, freezes all state
  input wire logic [dxt_pkg::ADR_W-1:0] i_avs_address, // Register byte address
  input wire logic i_avs_read, // Register read
  input wire logic i_avs_write, // Register write
  input wire logic [31:0] i_avs_writedata, // Register write data
  output logic [31:0] o_avs_readdata, // Register read data
  output logic o_avs_waitrequest, // Bus stall
  input wire logic i_dack_n, // DMA acknowledge, low
  input wire logic i_aen, // Address enable of DMA cycles
  input wire logic i_tc, // Terminal count, high
  input wire logic i_rd_n, // Read strobe, low
  input wire logic i_wr_n, // Write strobe, low
  input wire logic [7:0] i_isa_d, // Data bus in
  output logic [7:0] o_isa_d, // Data bus out
  output logic o_isa_d_oe, // Data bus drive enable
  output logic o_drq, // DMA request
  output logic o_irq, // Interrupt request
  input wire logic i_dsk_valid, // Disk byte arrives (read)
  input wire logic [7:0] i_dsk_data, // Disk byte
  input wire logic i_dsk_take, // Disk takes a byte (write)
  output logic [7:0] o_dsk_data // Byte for the disk
);
  import dxt_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_C = CW'(DEPTH);
  localparam logic [GAP_W-1:0] GAP_END = GAP_W'(GAP - 1);

  // The trigger arithmetic assumes a four-bit level over a 16-byte FIFO
  if (DEPTH != (1 << TRIG_W)) begin : g_depth_chk
    $error("DEPTH must equal 16");
  end
  if (GAP < 1 || GAP > (1 << GAP_W)) begin : g_gap_chk
    $error("GAP out of range");
  end

  // Pointer step, shared by head and tail
  function automatic logic [AW-1:0] f_inc(input logic [AW-1:0] p);
    return p + 1'b1;
  endfunction : f_inc

  // Last byte of a sector on a counter
  function automatic logic f_last(input logic [LEN_W-1:0] cnt, input logic [LEN_W-1:0] len);
    return cnt == len - 1'b1;
  endfunction : f_last

  // Pin synchronisers; first stages feed only second stages
  logic [1:0] dack_n_s, rd_n_s, wr_n_s, tc_s, aen_s;
  logic [7:0] dat_s0, dat_s1;
  logic dack_n_q, rd_n_q, wr_n_q; // Second stage one edge late

  // Software control
  logic fifo_en_reg, burst_reg, dma_gate_reg, non_dma_reg, alt_reg;
  logic [TRIG_W-1:0] trig_reg;
  logic dir_rd_reg; // Disk to host
  logic [NSEC_W-1:0] nsec_reg, secs_left_reg;
  logic [LEN_W-1:0] len_reg, in_cnt_reg, out_cnt_reg;

  // Execution and request state
  dxt_exec_t ex_reg, ex_next;
  dxt_req_t rq_reg;
  logic sess_reg; // Non-burst session still open
  logic [GAP_W-1:0] gap_reg;
  logic strobe_seen_reg; // Strobe seen under this acknowledge
  logic in_done_reg, ovr_reg, und_reg, tc_reg, end_irq_reg;

  // FIFO bookkeeping
  logic [AW-1:0] head_reg, tail_reg, head_next;
  logic [CW-1:0] cnt_reg;
  logic [7:0] isa_d_reg, dsk_q_reg;

  // Bus slave
  logic ack_reg;
  logic [31:0] rdata_reg;

  dxt_fifo_if #(.AW(AW), .DW(8)) fifo_bus ();

  dxt_fifo_mem #(.AW(AW), .DW(8)) u_mem (
    .i_ref_clk(i_ref_clk),
    .fifo(fifo_bus.mem)
  );

  // Pin edges and selects
  wire dack_lo = ~dack_n_s[1];
  wire dack_fall = dack_n_q & ~dack_n_s[1];
  wire dack_rise = ~dack_n_q & dack_n_s[1];
  wire rd_end = ~rd_n_q & rd_n_s[1];
  wire wr_end = ~wr_n_q & wr_n_s[1];
  wire cs_dma = dack_lo & aen_s[1];

  wire dma_on = dma_gate_reg & ~non_dma_reg;
  wire xfer = ex_reg == EX_XFER;
  wire flush = ex_reg == EX_FLUSH;
  wire empty = cnt_reg == '0;
  wire full = cnt_reg == FULL_C;

  // Bus handshake: one wait cycle, then the access is taken
  wire av_req = i_avs_read | i_avs_write;
  wire av_rd_acc = i_avs_read & ack_reg;
  wire av_wr_acc = i_avs_write & ack_reg;
  wire hit_data = i_avs_address == OFS_DATA;
  wire start = av_wr_acc & (i_avs_address == OFS_CMD) & (ex_reg == EX_IDLE);
  wire res_rd = av_rd_acc & (i_avs_address == OFS_RES);

  // acknowledged strobe or pulse, or the decoded data register, moves a byte
  wire host_xfer = xfer & ~dma_on & hit_data & (dir_rd_reg ? av_rd_acc : av_wr_acc);
  wire dma_xfer = xfer & dma_on & ((cs_dma & (dir_rd_reg ? rd_end : wr_end))
                                   | (dack_rise & aen_s[1] & ~strobe_seen_reg));
  wire byte_done = dma_xfer | host_xfer;

  // Disk side events
  wire dsk_in = dir_rd_reg & i_dsk_valid & (xfer | flush);
  wire dsk_out = ~dir_rd_reg & i_dsk_take & (xfer | flush);
  wire push = dir_rd_reg ? (dsk_in & xfer & ~full) : (byte_done & ~full & ~in_done_reg);
  wire pop = dir_rd_reg ? (byte_done & ~empty) : (dsk_out & xfer & ~empty);
  wire overrun = dsk_in & xfer & full;
  wire underrun = dsk_out & xfer & empty;
  wire tc_hit = xfer & dma_on & tc_s[1] & dack_lo;

  // Sector accounting
  wire in_ev = dir_rd_reg ? dsk_in : push;
  wire in_last = in_ev & f_last(in_cnt_reg, len_reg);
  wire out_last = dsk_out & f_last(out_cnt_reg, len_reg);
  wire sec_done = xfer ? (dir_rd_reg ? (in_done_reg & empty) : out_last)
                       : (flush & (dir_rd_reg ? (in_done_reg | in_last) : out_last));
  wire final_sec = (secs_left_reg == NSEC_LAST) | ovr_reg | und_reg | tc_reg | flush | underrun;
  wire next_sec = sec_done & ~final_sec;
  wire enter_res = (ex_next == EX_RESULT) & (ex_reg != EX_RESULT);
  wire clr = start | enter_res;

  wire [TRIG_W-1:0] thr = fifo_en_reg ? trig_reg : TRIG_DIS;
  wire [CW-1:0] thr_ext = CW'(thr);
  wire burst = fifo_en_reg & burst_reg;
  wire alt_nf = alt_reg & ~fifo_en_reg & dma_on;
  wire trig_hit = dir_rd_reg ? ((cnt_reg >= FULL_C - thr_ext) | (in_done_reg & ~empty))
                             : ((cnt_reg <= thr_ext) & ~in_done_reg);
  wire stop = dir_rd_reg ? empty : (full | in_done_reg);
  wire go = ~stop & (trig_hit | sess_reg);
  wire rq_on = rq_reg == RQ_ON;

  // Synchronise pins; strobes idle high
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dack_n_s <= 2'h3;
      rd_n_s <= 2'h3;
      wr_n_s <= 2'h3;
      tc_s <= 2'h0;
      aen_s <= 2'h0;
      dat_s0 <= 8'h00;
      dat_s1 <= 8'h00;
      dack_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else if (i_ce) begin
      dack_n_s <= {dack_n_s[0], i_dack_n};
      rd_n_s <= {rd_n_s[0], i_rd_n};
      wr_n_s <= {wr_n_s[0], i_wr_n};
      tc_s <= {tc_s[0], i_tc};
      aen_s <= {aen_s[0], i_aen};
      dat_s0 <= i_isa_d;
      dat_s1 <= dat_s0;
      dack_n_q <= dack_n_s[1];
      rd_n_q <= rd_n_s[1];
      wr_n_q <= wr_n_s[1];
    end
  end

  // Control register; reset disables FIFO
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      fifo_en_reg <= 1'b0;
      burst_reg <= 1'b0;
      dma_gate_reg <= 1'b0;
      non_dma_reg <= 1'b0;
      alt_reg <= 1'b0;
      trig_reg <= '0;
    end else if (i_ce && av_wr_acc && i_avs_address == OFS_CTRL) begin
      fifo_en_reg <= i_avs_writedata[CTL_FIFO_EN];
      burst_reg <= i_avs_writedata[CTL_BURST];
      dma_gate_reg <= i_avs_writedata[CTL_DMA_GATE];
      non_dma_reg <= i_avs_writedata[CTL_NON_DMA];
      alt_reg <= i_avs_writedata[CTL_ALT];
      trig_reg <= i_avs_writedata[CTL_TRIG_LSB +: TRIG_W];
    end
  end

  // Command latched only from idle; later writes are ignored
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dir_rd_reg <= 1'b0;
      nsec_reg <= NSEC_RST;
      len_reg <= LEN_RST;
    end else if (i_ce && start) begin
      dir_rd_reg <= i_avs_writedata[CMD_DIR];
      nsec_reg <= i_avs_writedata[CMD_NSEC_LSB +: NSEC_W];
      len_reg <= i_avs_writedata[CMD_LEN_LSB +: LEN_W];
    end
  end

  // Execution phase sequence
  always_comb begin
    ex_next = ex_reg;
    case (ex_reg)
      EX_IDLE: begin
        if (start) ex_next = EX_XFER;
      end
      EX_XFER: begin
        if (sec_done && final_sec) ex_next = EX_RESULT;
        else if (underrun || tc_hit) ex_next = EX_FLUSH;
      end
      EX_FLUSH: begin
        if (sec_done) ex_next = EX_RESULT;
      end
      EX_RESULT: begin
        if (res_rd) ex_next = EX_IDLE;
      end
      default: ex_next = EX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) ex_reg <= EX_IDLE;
    else if (i_ce) ex_reg <= ex_next;
  end

  // Sector counters; a new sector reopens the write request
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      in_cnt_reg <= '0;
      out_cnt_reg <= '0;
      in_done_reg <= 1'b0;
      secs_left_reg <= NSEC_RST;
    end else if (i_ce) begin
      if (start) begin
        in_cnt_reg <= '0;
        out_cnt_reg <= '0;
        in_done_reg <= 1'b0;
        secs_left_reg <= i_avs_writedata[CMD_NSEC_LSB +: NSEC_W];
      end else if (next_sec) begin
        in_cnt_reg <= '0;
        out_cnt_reg <= '0;
        in_done_reg <= 1'b0;
        secs_left_reg <= secs_left_reg - 1'b1;
      end else begin
        if (in_ev) in_cnt_reg <= in_cnt_reg + 1'b1;
        if (dsk_out) out_cnt_reg <= out_cnt_reg + 1'b1;
        if (in_last) in_done_reg <= 1'b1;
      end
    end
  end

  // Error and count flags, cleared at command start
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ovr_reg <= 1'b0;
      und_reg <= 1'b0;
      tc_reg <= 1'b0;
    end else if (i_ce) begin
      if (start) begin
        ovr_reg <= 1'b0;
        und_reg <= 1'b0;
        tc_reg <= 1'b0;
      end else begin
        if (overrun) ovr_reg <= 1'b1;
        if (underrun) und_reg <= 1'b1;
        if (tc_hit) tc_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) end_irq_reg <= 1'b0;
    else if (i_ce) begin
      if (enter_res) end_irq_reg <= 1'b1;
      else if (res_rd) end_irq_reg <= 1'b0;
    end
  end

  // FIFO pointers and count; emptied at start and at result
  assign head_next = clr ? '0 : (pop ? f_inc(head_reg) : head_reg);
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      head_reg <= '0;
      tail_reg <= '0;
      cnt_reg <= '0;
    end else if (i_ce) begin
      head_reg <= head_next;
      if (clr) begin
        tail_reg <= '0;
        cnt_reg <= '0;
      end else begin
        if (push) tail_reg <= f_inc(tail_reg);
        if (push && !pop) cnt_reg <= cnt_reg + 1'b1;
        else if (pop && !push) cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  assign fifo_bus.ce = i_ce;
  assign fifo_bus.we = push & ~clr;
  assign fifo_bus.waddr = tail_reg;
  assign fifo_bus.wdata = dir_rd_reg ? i_dsk_data : (dma_on ? dat_s1 : i_avs_writedata[7:0]);
  assign fifo_bus.raddr = head_next;

  // Output bytes; the disk byte holds on underrun, which pads the sector
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      isa_d_reg <= 8'h00;
      dsk_q_reg <= 8'h00;
    end else if (i_ce) begin
      isa_d_reg <= fifo_bus.rdata;
      if (pop && !dir_rd_reg) dsk_q_reg <= fifo_bus.rdata;
    end
  end

  // Strobe memory under one acknowledge, for strobeless pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) strobe_seen_reg <= 1'b0;
    else if (i_ce) begin
      if (dack_fall) strobe_seen_reg <= 1'b0;
      else if (cs_dma && (rd_end || wr_end)) strobe_seen_reg <= 1'b1;
    end
  end

  // Service request; idle until execution
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rq_reg <= RQ_OFF;
      gap_reg <= '0;
    end else if (i_ce) begin
      case (rq_reg)
        RQ_OFF: begin
          gap_reg <= '0;
          if (byte_done && !burst && !alt_nf) rq_reg <= RQ_GAP;
          else if (xfer && go && !(dma_on && dack_lo)) rq_reg <= RQ_ON;
        end
        RQ_ON: begin
          if (!xfer || stop || (!dir_rd_reg && in_last)) rq_reg <= RQ_OFF;
          else if (byte_done && !burst) rq_reg <= alt_nf ? RQ_OFF : RQ_GAP;
          else if (dma_on && dack_fall && !burst) rq_reg <= RQ_OFF;
        end
        RQ_GAP: begin
          if (gap_reg == GAP_END || !xfer) rq_reg <= RQ_OFF;
          gap_reg <= gap_reg + 1'b1;
        end
        default: rq_reg <= RQ_OFF;
      endcase
    end
  end

  // Session keeps a non-burst service running below threshold
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) sess_reg <= 1'b0;
    else if (i_ce) begin
      if (!xfer || stop) sess_reg <= 1'b0;
      else if (rq_on) sess_reg <= 1'b1;
    end
  end

  // Bus slave: read data latched in the wait cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else if (i_ce) begin
      ack_reg <= av_req & ~ack_reg;
      if (i_avs_read && !ack_reg) begin
        rdata_reg <= 32'h0;
        case (i_avs_address)
          OFS_CTRL: begin
            rdata_reg[CTL_FIFO_EN] <= fifo_en_reg;
            rdata_reg[CTL_BURST] <= burst_reg;
            rdata_reg[CTL_DMA_GATE] <= dma_gate_reg;
            rdata_reg[CTL_NON_DMA] <= non_dma_reg;
            rdata_reg[CTL_ALT] <= alt_reg;
            rdata_reg[CTL_TRIG_LSB +: TRIG_W] <= trig_reg;
          end
          OFS_CMD: begin
            rdata_reg[CMD_DIR] <= dir_rd_reg;
            rdata_reg[CMD_NSEC_LSB +: NSEC_W] <= nsec_reg;
            rdata_reg[CMD_LEN_LSB +: LEN_W] <= len_reg;
          end
          OFS_STAT: begin
            rdata_reg[ST_RQM] <= (ex_reg == EX_IDLE) | (ex_reg == EX_RESULT) | (xfer & ~dma_on & rq_on);
            rdata_reg[ST_DIO] <= (ex_reg == EX_RESULT) | (xfer & dir_rd_reg);
            rdata_reg[ST_NDMA] <= xfer & ~dma_on;
            rdata_reg[ST_BUSY] <= ex_reg != EX_IDLE;
            rdata_reg[ST_OVR] <= ovr_reg;
            rdata_reg[ST_UND] <= und_reg;
            rdata_reg[ST_TC] <= tc_reg;
            rdata_reg[ST_CNT_LSB +: CW] <= cnt_reg;
          end
          OFS_DATA: rdata_reg[7:0] <= fifo_bus.rdata;
          OFS_RES: begin
            rdata_reg[RES_OVR] <= ovr_reg;
            rdata_reg[RES_UND] <= und_reg;
            rdata_reg[RES_TC] <= tc_reg;
          end
          default: rdata_reg <= 32'h0;
        endcase
      end
    end
  end

  assign o_avs_waitrequest = av_req & ~ack_reg;
  assign o_avs_readdata = rdata_reg;
  assign o_isa_d = isa_d_reg;
  assign o_isa_d_oe = xfer & dma_on & dir_rd_reg & cs_dma & ~rd_n_s[1];
  assign o_dsk_data = dsk_q_reg;
  assign o_drq = dma_on & rq_on;
  assign o_irq = (~dma_on & xfer & rq_on) | end_irq_reg;
endmodule : dxt_exec_xfer

// ==== hw/dxt_fifo_if.sv ====
// Storage port between the transfer controller and its FIFO memory.
// Assumes one clock; the memory answers one edge after the read address.
`timescale 1ns/1ps
interface dxt_fifo_if #(parameter int AW = 4, parameter int DW = 8);
  logic ce; // Clock enable
  logic we; // Write strobe
  logic [AW-1:0] waddr; // Write address
  logic [DW-1:0] wdata; // Write data
  logic [AW-1:0] raddr; // Read address for next edge
  logic [DW-1:0] rdata; // Registered read data
  modport ctrl (output ce, we, waddr, wdata, raddr, input rdata);
  modport mem (input ce, we, waddr, wdata, raddr, output rdata);
endinterface : dxt_fifo_if

// ==== hw/dxt_fifo_mem.sv ====
// Byte store of the transfer FIFO with registered read data.
// Assumes the controller drives the next head address, so data never lags.
`timescale 1ns/1ps
module dxt_fifo_mem #(
  parameter int AW = 4, // Address width
  parameter int DW = 8 // Data width
)(
  input wire logic i_ref_clk, // Controller clock
  dxt_fifo_if.mem fifo // Storage port
);
  logic [DW-1:0] mem_reg [2**AW]; // Byte cells
  logic [DW-1:0] q_reg; // Read data register

  // Store a byte
  always_ff @(posedge i_ref_clk) begin
    if (fifo.ce && fifo.we) begin
      mem_reg[fifo.waddr] <= fifo.wdata;
    end
  end

  // Read with bypass, so a byte written to the head shows at once
  always_ff @(posedge i_ref_clk) begin
    if (fifo.ce) begin
      q_reg <= (fifo.we && fifo.waddr == fifo.raddr) ? fifo.wdata : mem_reg[fifo.raddr];
    end
  end

  assign fifo.rdata = q_reg;
endmodule : dxt_fifo_mem

// ==== hw/dxt_pkg.sv ====
// Constants, field layouts and state types of the execution-phase transfer block.
// Assumes a 50 MHz controller clock and a 32-bit Avalon-MM register bus.
package dxt_pkg;
  // Clock period and request gap timing
  localparam int CLK_NS = 20;
  localparam int GAP_NS = 350;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_W = 6;
  // Drop time of the request; the pin synchronisers make it three cycles
  localparam int DROP_NS = 50;
  localparam int DROP_CYC = (DROP_NS / CLK_NS < 1) ? 1 : DROP_NS / CLK_NS;
  // FIFO shape and trigger level
  localparam int FIFO_DEPTH = 16;
  localparam int TRIG_W = 4;
  localparam logic [3:0] TRIG_DIS = 4'hf;
  // Register byte offsets
  localparam int ADR_W = 5;
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_CMD = 5'h04;
  localparam logic [4:0] OFS_STAT = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;
  localparam logic [4:0] OFS_RES = 5'h10;
  // Control register fields
  localparam int CTL_FIFO_EN = 0;
  localparam int CTL_BURST = 1;
  localparam int CTL_DMA_GATE = 2;
  localparam int CTL_NON_DMA = 3;
  localparam int CTL_ALT = 4;
  localparam int CTL_TRIG_LSB = 8;
  // Command register fields
  localparam int CMD_DIR = 0;
  localparam int CMD_NSEC_LSB = 8;
  localparam int NSEC_W = 8;
  localparam int CMD_LEN_LSB = 16;
  localparam int LEN_W = 16;
  localparam logic [7:0] NSEC_LAST = 8'h01;
  localparam logic [7:0] NSEC_RST = 8'h01;
  localparam logic [15:0] LEN_RST = 16'h0200;
  // Main status fields
  localparam int ST_BUSY = 4;
  localparam int ST_NDMA = 5;
  localparam int ST_DIO = 6;
  localparam int ST_RQM = 7;
  localparam int ST_OVR = 8;
  localparam int ST_UND = 9;
  localparam int ST_TC = 10;
  localparam int ST_CNT_LSB = 16;
  // Result word fields
  localparam int RES_OVR = 0;
  localparam int RES_UND = 1;
  localparam int RES_TC = 2;
  // Execution phase states
  typedef enum logic [3:0] {
    EX_IDLE = 4'b0001,
    EX_XFER = 4'b0010,
    EX_FLUSH = 4'b0100,
    EX_RESULT = 4'b1000
  } dxt_exec_t;
  // Service request states
  typedef enum logic [2:0] {
    RQ_OFF = 3'b001,
    RQ_ON = 3'b010,
    RQ_GAP = 3'b100
  } dxt_req_t;
endpackage : dxt_pkg

// ==== tb/dxt_dma_model.sv ====
// System DMA controller model: one acknowledged read strobe per request.
// Assumes the device drops its request on the acknowledge edge.
`timescale 1ns/1ps
module dxt_dma_model (
  input wire logic i_ref_clk, // Clock
  input wire logic i_drq, // Request
  input wire logic [7:0] i_isa_d, // Bus from device
  output logic o_dack_n, // Acknowledge, low
  output logic o_aen, // Address enable
  output logic o_rd_n, // Read strobe, low
  output logic [7:0] o_isa_d, // Bus to device
  output logic o_got, // Byte taken pulse
  output logic [7:0] o_byte // Taken byte
);
  // Undriven bus toggles so a stale value is never mistaken for data
  always @(posedge i_ref_clk) o_isa_d <= ~o_isa_d;
  initial begin
    o_dack_n = 1'b1;
    o_aen = 1'b0;
    o_rd_n = 1'b1;
    o_got = 1'b0;
    o_isa_d = 8'h5a;
    forever begin
      @(posedge i_ref_clk);
      o_got <= 1'b0;
      if (i_drq === 1'b1) begin
        o_dack_n <= 1'b0;
        o_aen <= 1'b1;
        // Strobes stay four cycles to clear the pin synchronisers
        repeat (4) @(posedge i_ref_clk);
        o_rd_n <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        o_byte <= i_isa_d;
        o_got <= 1'b1;
        o_rd_n <= 1'b1;
        // Taken pulse lasts one cycle, so the bench matches each byte once
        @(posedge i_ref_clk);
        o_got <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        o_dack_n <= 1'b1;
        o_aen <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
      end
    end
  end
endmodule : dxt_dma_model

// ==== tb/dxt_exec_xfer_props.sv ====
// Checker on the top ports of the execution-phase transfer block.
// Assumes i_ce high and legacy non-burst DMA traffic.
`timescale 1ns/1ps
module dxt_exec_xfer_props #(parameter int GAP = 18) (
  input wire logic i_ref_clk, // Clock
  input wire logic i_reset, // Reset, high
  input wire logic [dxt_pkg::ADR_W-1:0] i_avs_address, // Address
  input wire logic i_avs_read, // Read
  input wire logic i_avs_write, // Write
  input wire logic [31:0] o_avs_readdata, // Read data
  input wire logic o_avs_waitrequest, // Stall
  input wire logic i_dack_n, // Acknowledge, low
  input wire logic o_isa_d_oe, // Bus drive
  input wire logic o_drq, // DMA request
  input wire logic o_irq // Interrupt
);
  import dxt_pkg::*;
  logic [5:0] low_cnt; // Request low time, saturating
  // Reset counts as a long quiet time, so the first rise is legal
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) low_cnt <= 6'h3f;
    else if (o_drq) low_cnt <= 6'h00;
    else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  a_reset_quiet: assert property ($past(i_reset) |-> !o_drq && !o_irq)
    else $error("request active after reset");
  a_wait_one: assert property (o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus stall longer than one cycle");
  a_wait_cause: assert property (o_avs_waitrequest |-> i_avs_read || i_avs_write)
    else $error("bus stall without request");
  a_dack_drop: assert property ($fell(i_dack_n) |-> ##[1:5] !o_drq)
    else $error("request kept after acknowledge");
  a_gap_held: assert property ($rose(o_drq) |-> low_cnt >= GAP - 1)
    else $error("request gap too short");
  a_end_clear: assert property (i_avs_read && i_avs_address == OFS_RES && !o_avs_waitrequest
    |-> ##[1:3] !o_irq)
    else $error("end interrupt not cleared");
  a_irq_alone: assert property (!(o_drq && o_irq))
    else $error("interrupt and request together");
  a_rdata_hold: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data moved without read");
  a_drive_sel: assert property (o_isa_d_oe |-> !$past(i_dack_n, 2) || !$past(i_dack_n, 3))
    else $error("bus driven without acknowledge");
endmodule : dxt_exec_xfer_props

// ==== tb/dxt_exec_xfer_tb.sv ====
// Bench for the transfer block: legacy DMA read of one short sector, then a non-DMA write of one.
// Assumes the DMA model on the ISA side and a 50 MHz clock.
`timescale 1ns/1ps
module dxt_exec_xfer_tb;
  import dxt_pkg::*;
  localparam int GAP = 4; // Shortened request gap
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wait_rq, dack_n, aen, rd_n, oe, drq, irq, got, dv = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0] bus_in, bus_out, dbyte, dk = 8'h00;
  logic [7:0] exp_q[$]; // Bytes the host should see
  logic tk = 1'b0, tk_q = 1'b0; // Disk take and its delayed copy
  logic [7:0] dq, wb; // Byte for the disk, host byte written
  logic [7:0] exp_d[$]; // Bytes the disk should see
  logic [31:0] cfg; // Expected control word
  int num_errors = 0, tests_run = 0, cyc = 0;
  dxt_exec_xfer #(.GAP(GAP)) uut (.i_ref_clk(clk), .i_reset(rst), .i_ce(1'b1), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wait_rq), .i_dack_n(dack_n), .i_aen(aen), .i_tc(1'b0), .i_rd_n(rd_n),
    .i_wr_n(1'b1), .i_isa_d(bus_in), .o_isa_d(bus_out), .o_isa_d_oe(oe), .o_drq(drq), .o_irq(irq),
    .i_dsk_valid(dv), .i_dsk_data(dk), .i_dsk_take(tk), .o_dsk_data(dq));
  dxt_dma_model dma (.i_ref_clk(clk), .i_drq(drq), .i_isa_d(bus_out), .o_dack_n(dack_n), .o_aen(aen),
    .o_rd_n(rd_n), .o_isa_d(bus_in), .o_got(got), .o_byte(dbyte));
  initial forever #10 clk = ~clk;
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task close_out;
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // Holds the request until the edge that samples the stall low
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wait_rq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  // Each byte the DMA side takes is matched against the oldest note
  always @(posedge clk) if (got === 1'b1 && dma.o_rd_n === 1'b1) chk("dma byte", exp_q.pop_front(), dbyte);
  // The disk byte shows the cycle after its take
  always @(posedge clk) begin
    tk_q <= tk;
    if (tk_q) chk("disk byte", exp_d.pop_front(), dq);
  end
  always @(posedge clk) if (++cyc == 20000) begin
    num_errors++;
    close_out();
  end
  initial begin
    void'($urandom(32'h20970bc5));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, q);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("idle status", 32'h80, q & 32'he0);
    cfg = {$urandom} & 32'h00000f00 | 32'h4;
    bus(1'b1, OFS_CTRL, cfg);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl readback", cfg, q);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'b1, OFS_CMD, 32'h00040101);
    // Bytes spaced so each is served before the next arrives
    repeat (4) begin
      dk <= 8'($urandom);
      dv <= 1'b1;
      @(posedge clk);
      exp_q.push_back(dk);
      dv <= 1'b0;
      repeat (60) @(posedge clk);
    end
    repeat (200) if (irq !== 1'b1) @(posedge clk);
    chk("end irq", 1'b1, irq);
    chk("bytes left", 32'h0, exp_q.size());
    bus(1'b0, OFS_RES, 32'h0);
    chk("result", 32'h0, q & 32'h7);
    repeat (3) @(posedge clk);
    chk("irq cleared", 1'b0, irq);
    // Non-DMA write of a two-byte sector; each byte drops the interrupt, and the next byte does not wait for it
    bus(1'b1, OFS_CTRL, 32'h8);
    bus(1'b1, OFS_CMD, 32'h00020100);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("non-DMA status", 32'ha0, q & 32'he0);
    chk("data irq", 1'b1, irq);
    repeat (2) begin
      wb = 8'($urandom);
      exp_d.push_back(wb);
      bus(1'b1, OFS_DATA, {24'h0, wb});
      @(posedge clk);
      chk("irq per byte", 1'b0, irq);
    end
    repeat (2) begin
      tk <= 1'b1;
      @(posedge clk);
      tk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (20) if (irq !== 1'b1) @(posedge clk);
    chk("write end irq", 1'b1, irq);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("result status", 32'hc0, q & 32'he0);
    bus(1'b0, OFS_RES, 32'h0);
    chk("write result", 32'h0, q & 32'h7);
    chk("disk bytes left", 32'h0, exp_d.size());
    close_out();
  end
endmodule : dxt_exec_xfer_tb
bind dxt_exec_xfer dxt_exec_xfer_props #(.GAP(GAP)) u_props (.i_ref_clk, .i_reset, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_dack_n, .o_isa_d_oe, .o_drq, .o_irq);
